// File: dv/csp_host_model.sv
// host-side model: executes replayed lines and reads back stored lines
`timescale 1ns/10ps
`default_nettype none
module csp_host_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic exec_valid,
  output var logic  exec_ready,
  input  wire logic rd_valid,
  output var logic  rd_ready
);
  logic [1:0] n = 2'h0;
  initial begin
    exec_ready = 1'b0;
    rd_ready = 1'b0;
  end
  // a busy host stalls the exec port up to three cycles and the readback port one cycle at a time
  always @(negedge clk) begin
    n <= n + 2'h1;
    exec_ready <= exec_valid && (!slow || n == 2'h3);
    rd_ready <= rd_valid && (!slow || n[0]);
  end
endmodule
`default_nettype wire

// File: dv/csp_player_sva.sv
// port assertions for the command sequence player
`timescale 1ns/10ps
`default_nettype none
module csp_player_sva
  import csp_pkg::*;
#(
  parameter int DEPTH  = 64,
  parameter int LINE_W = 256
) (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   cmd_valid,
  input wire logic                   cmd_ready,
  input wire csp_op_t                cmd_op,
  input wire csp_src_t               cmd_src,
  input wire logic [15:0]            cmd_arg,
  input wire logic                   exec_valid,
  input wire logic                   exec_ready,
  input wire logic [LINE_W-1:0]      exec_line,
  input wire logic                   rd_valid,
  input wire logic                   rd_ready,
  input wire logic [LINE_W-1:0]      rd_line,
  input wire logic                   recording,
  input wire csp_run_t               run_state,
  input wire logic [7:0]             dwell_s,
  input wire logic [15:0]            repeat_count,
  input wire logic [$clog2(DEPTH):0] seq_len,
  input wire logic                   cmd_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // commands that act at once instead of being stored
  wire logic acc = cmd_valid && cmd_ready && !recording;
  chk_ready_rdback: assert property (acc && cmd_op == CSP_OP_READBACK && seq_len != '0
    |=> rd_valid && !cmd_ready) else $error("command port open during readback");
  chk_rdback_hold: assert property (rd_valid && !rd_ready
    |=> rd_valid && $stable(rd_line)) else $error("readback line dropped");
  chk_dwell_set: assert property (acc && cmd_op == CSP_OP_SET_DWELL && cmd_arg <= 16'h00B4
    |=> {8'h00, dwell_s} == $past(cmd_arg) && !cmd_err) else $error("dwell not taken");
  chk_dwell_refuse: assert property (acc && cmd_op == CSP_OP_SET_DWELL && cmd_arg > 16'h00B4
    |=> cmd_err && dwell_s == $past(dwell_s)) else $error("dwell out of range taken");
  chk_repeat_lock: assert property (acc && run_state != CSP_RUN_IDLE
    && cmd_op inside {CSP_OP_SET_REPEAT, CSP_OP_SET_ENDLESS} |=> cmd_err && $stable(repeat_count))
    else $error("repeat changed during run");
  chk_rec_clear: assert property (acc && cmd_op == CSP_OP_REC_START
    && cmd_src inside {CSP_SRC_SERIAL, CSP_SRC_USB} |=> recording && seq_len == '0)
    else $error("recording did not start empty");
  chk_rec_store: assert property (cmd_valid && cmd_ready && recording
    && cmd_op != CSP_OP_REC_STOP && seq_len < DEPTH |=> seq_len == $past(seq_len) + 1'b1)
    else $error("recorded line not stored");
  chk_exec_hold: assert property (exec_valid && !exec_ready && !cmd_valid
    |=> exec_valid && $stable(exec_line)) else $error("offered line dropped");
  chk_start_issue: assert property (acc && run_state == CSP_RUN_IDLE && seq_len != '0
    && cmd_op inside {CSP_OP_STATE_RUN, CSP_OP_TRIGGER, CSP_OP_LAUNCH} ##1 !cmd_valid
    |-> run_state == CSP_RUN_NEXT ##1 exec_valid) else $error("start did not issue");
  chk_zero_dwell: assert property (exec_valid && exec_ready && dwell_s == 8'h00
    && !cmd_valid |=> run_state == CSP_RUN_WAIT) else $error("zero dwell not entered");
  // a pause or stop taken in the wait cycle legally redirects the engine
  chk_zero_next: assert property (exec_valid && exec_ready && dwell_s == 8'h00
    && !cmd_valid ##1 !cmd_valid |=> run_state == CSP_RUN_NEXT) else $error("zero dwell waited");
endmodule
bind csp_player csp_player_sva #(.DEPTH(DEPTH), .LINE_W(LINE_W)) i_csp_player_sva (
  .clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_src, .cmd_arg, .exec_valid,
  .exec_ready, .exec_line, .rd_valid, .rd_ready, .rd_line, .recording, .run_state, .dwell_s,
  .repeat_count, .seq_len, .cmd_err
);
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the command sequence player
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import csp_pkg::*;
  logic         clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, slow = 1'b0;
  csp_op_t      cmd_op = CSP_OP_HOST;
  csp_src_t     cmd_src = CSP_SRC_USB;
  logic [15:0]  cmd_arg = 16'h0000, repeat_count, rp [4];
  logic [255:0] cmd_line = '0, exec_line, rd_line, ln [3], exp_q [$];
  logic         cmd_ready, exec_valid, exec_ready, rd_valid, rd_ready, rd_last;
  logic         recording, repeat_endless, cmd_err;
  csp_run_t     run_state;
  logic [7:0]   dwell_s;
  logic [6:0]   seq_len;
  int           err_count = 0, checks = 0, cyc = 0;
  integer       seed = 32'h57AC4499;
  csp_player #(.TICK_CYCLES(4)) i_csp_player (.clk, .reset_n, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_src, .cmd_arg, .cmd_line, .exec_valid, .exec_ready, .exec_line, .rd_valid,
    .rd_ready, .rd_line, .rd_last, .recording, .run_state, .dwell_s, .repeat_count,
    .repeat_endless, .seq_len, .cmd_err);
  csp_host_model i_csp_host_model (.clk, .slow, .exec_valid, .exec_ready, .rd_valid, .rd_ready);
  task automatic chk(input logic [255:0] s, input logic [255:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cmd(input csp_op_t o, input csp_src_t s = CSP_SRC_USB,
                     input logic [15:0] a = 16'h0000, input logic [255:0] l = '0);
    @(negedge clk);
    slow = 1'($random(seed));
    cmd_op = o;
    cmd_src = s;
    cmd_arg = a;
    cmd_line = l;
    cmd_valid = 1'b1;
    while (!cmd_ready) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_q;
    repeat (500) if (exp_q.size() != 0 || run_state != CSP_RUN_IDLE || rd_valid) @(negedge clk);
    chk(exp_q.size(), 0);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // each line taken off either port must match the oldest noted line
  always @(posedge clk) begin
    if (exec_valid && exec_ready) chk(exec_line, exp_q.size() ? exp_q.pop_front() : 'x);
    if (rd_valid && rd_ready) begin
      chk(rd_last, exp_q.size() == 1);
      chk(rd_line, exp_q.size() ? exp_q.pop_front() : 'x);
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    chk(repeat_count, 16'h0001);
    foreach (ln[i]) ln[i] = {8{$random(seed)}};
    cmd(CSP_OP_REC_START, CSP_SRC_SERIAL);
    cmd(CSP_OP_HOST, CSP_SRC_SERIAL, 16'h0000, ln[0]);
    cmd(CSP_OP_SET_DWELL, CSP_SRC_SERIAL, 16'h00C8, ln[1]);
    cmd(CSP_OP_HOST, CSP_SRC_SERIAL, 16'h0000, ln[2]);
    cmd(CSP_OP_REC_STOP, CSP_SRC_SERIAL);
    chk(seq_len, 7'h03);
    chk(dwell_s, 8'h00);
    exp_q = {ln[0], ln[1], ln[2]};
    cmd(CSP_OP_READBACK);
    chk(cmd_ready, 1'b0);
    wait_q();
    cmd(CSP_OP_SET_DWELL, CSP_SRC_LAN, 16'h00B5);
    chk(cmd_err, 1'b1);
    cmd(CSP_OP_SET_DWELL, CSP_SRC_LAN, 16'h0001);
    rp = '{16'h0000, 16'hFFFF, 16'hFFFE, 16'h0002};
    foreach (rp[i]) begin
      cmd(CSP_OP_SET_REPEAT, CSP_SRC_BUS, rp[i]);
      chk(cmd_err, rp[i] < 16'h0001 || rp[i] > 16'hFFFE);
    end
    exp_q = {ln[0], ln[1], ln[2], ln[0], ln[1], ln[2]};
    cmd(CSP_OP_STATE_RUN, CSP_SRC_LAN);
    cmd(CSP_OP_SET_REPEAT, CSP_SRC_LAN, 16'h0005);
    chk(repeat_count, 16'h0002);
    cmd(CSP_OP_SET_DWELL, CSP_SRC_LAN, 16'h0000);
    chk(dwell_s, 8'h00);
    wait_q();
    cmd(CSP_OP_SET_REPEAT, CSP_SRC_LAN, 16'h0001);
    exp_q = {ln[0], ln[1], ln[2]};
    cmd(CSP_OP_TRIGGER);
    @(posedge clk iff (exec_valid && exec_ready));
    cmd(CSP_OP_STATE_PAUSE);
    chk(run_state, CSP_RUN_PAUSED);
    cmd(CSP_OP_LAUNCH);
    wait_q();
    cmd(CSP_OP_SET_ENDLESS);
    chk(repeat_endless, 1'b1);
    exp_q = {ln[0], ln[1]};
    cmd(CSP_OP_STATE_RUN);
    repeat (2) @(posedge clk iff (exec_valid && exec_ready));
    cmd(CSP_OP_STATE_STOP);
    chk(run_state, CSP_RUN_IDLE);
    repeat (20) @(negedge clk);
    wait_q();
    cmd(CSP_OP_DELETE);
    chk(seq_len, 7'h00);
    cmd(CSP_OP_STATE_RUN);
    chk(cmd_err, 1'b1);
    cmd(CSP_OP_REC_START, CSP_SRC_BUS);
    chk({cmd_err, recording}, 2'b10);
    cmd(CSP_OP_SET_DWELL, CSP_SRC_USB, 16'h0007);
    cmd(CSP_OP_REC_START);
    repeat (64) cmd(CSP_OP_HOST, CSP_SRC_USB, 16'h0000, ln[2]);
    chk(seq_len, 7'h40);
    cmd(CSP_OP_HOST, CSP_SRC_USB, 16'h0000, ln[0]);
    chk({cmd_err, seq_len}, 8'hC0);
    // power loss in mid-recording must leave an empty buffer and default settings
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk({recording, repeat_endless, seq_len, repeat_count}, 25'h0000001);
    chk(dwell_s, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire

// File: verilog/csp_params.svh
// constants for the command sequence player
//
// Overview of operation
// - after begin-recording, store every following command in order until end-recording; the code keeps only 64 and flags the rest with cmd_err.
// - begin-recording first discards any sequence already held.
// - recorded commands are stored without syntax checks, malformed ones kept unchanged.
// - delay setting accepts integers 0 to 180 seconds, one second resolution.
// - during replay wait the configured delay after each command before the next.
// - a delay command met during replay updates the delay for all later waits.
// - replayed commands execute exactly as if the host had just sent them.
// - run state, trigger and launch_sequence_cmd start execution from current position.
// - stop state value ends sequence execution.
// - pause halts at current command; a later run resumes at the following one.
// - sequence runs to its end, repeats until count used up; count is 1 after reset.
// - repeat count accepts 1 to 65534, or endless_loop_token for unlimited repeats.
// - repeat count changes are ignored while a sequence runs or is paused.
// - readback returns every stored command, in stored order, one line each.
// - delete-sequence empties the buffer entirely.
// - the buffer is volatile; its contents are lost when power is removed.
// - host commands are accepted and acted on while a sequence executes.
// - bulk reload is supported over serial and USB only, not instrument bus or LAN; the code refuses only bus and LAN, so CSP_SRC_REPLAY is also taken.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

`define CSP_CLK_HZ        250000000
`define CSP_DWELL_UNIT_S  1
`define CSP_TICK_CYCLES   (`CSP_CLK_HZ * `CSP_DWELL_UNIT_S)
`define CSP_DWELL_MAX     180
`define CSP_REPEAT_MIN    1
`define CSP_REPEAT_MAX    65534
`define CSP_REPEAT_RST    16'h0001
`define CSP_DWELL_RST     8'h00
`define CSP_ARG_W         16
`define CSP_DEPTH         64
`define CSP_LINE_W        256

`endif

// File: verilog/csp_pkg.sv
// types shared by the command sequence player
`default_nettype none
package csp_pkg;

  typedef enum logic [3:0] {
    CSP_OP_HOST,
    CSP_OP_REC_START,
    CSP_OP_REC_STOP,
    CSP_OP_SET_DWELL,
    CSP_OP_SET_REPEAT,
    CSP_OP_SET_ENDLESS,
    CSP_OP_STATE_RUN,
    CSP_OP_STATE_STOP,
    CSP_OP_STATE_PAUSE,
    CSP_OP_TRIGGER,
    CSP_OP_LAUNCH,
    CSP_OP_READBACK,
    CSP_OP_DELETE
  } csp_op_t;

  typedef enum logic [2:0] {
    CSP_SRC_SERIAL,
    CSP_SRC_USB,
    CSP_SRC_BUS,
    CSP_SRC_LAN,
    CSP_SRC_REPLAY
  } csp_src_t;

  typedef enum logic [2:0] {
    CSP_RUN_IDLE,
    CSP_RUN_NEXT,
    CSP_RUN_ISSUE,
    CSP_RUN_WAIT,
    CSP_RUN_PAUSED
  } csp_run_t;

endpackage
`default_nettype wire

// File: verilog/csp_player.sv
// command sequence player: record, replay with dwell, repeat, readback, delete
`timescale 1ns/10ps
`default_nettype none
`include "csp_params.svh"

module csp_player
  import csp_pkg::*;
#(
  parameter int DEPTH       = `CSP_DEPTH,
  parameter int LINE_W      = `CSP_LINE_W,
  parameter int TICK_CYCLES = `CSP_TICK_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire csp_op_t               cmd_op,
  input  wire csp_src_t              cmd_src,
  input  wire logic [`CSP_ARG_W-1:0] cmd_arg,
  input  wire logic [LINE_W-1:0]     cmd_line,
  output logic                       exec_valid,
  input  wire logic                  exec_ready,
  output logic [LINE_W-1:0]          exec_line,
  output logic                       rd_valid,
  input  wire logic                  rd_ready,
  output logic [LINE_W-1:0]          rd_line,
  output logic                       rd_last,
  output logic                       recording,
  output csp_run_t                   run_state,
  output logic [7:0]                 dwell_s,
  output logic [15:0]                repeat_count,
  output logic                       repeat_endless,
  output logic [$clog2(DEPTH):0]     seq_len,
  output logic                       cmd_err
);

  localparam int AW = $clog2(DEPTH);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [DEPTH-1:0][LINE_W-1:0] mem;
    logic [AW:0]                  len;
    logic [AW:0]                  pos;
    csp_run_t                     run;
    logic                         rec;
    logic [7:0]                   dwell;
    logic [15:0]                  rep;
    logic                         endless;
    logic [15:0]                  passes;
    logic [7:0]                   wait_s;
    logic [TW-1:0]                tick;
    logic                         rb;
    logic [AW:0]                  rb_idx;
    logic [LINE_W-1:0]            rd_line;
    logic [LINE_W-1:0]            ex_line;
    logic                         err;
  } csp_st_t;

  csp_st_t st_r;
  csp_st_t st_nxt;
  logic    take;
  logic    start_req;

  // the parser is stalled while readback drains so lines never interleave
  assign cmd_ready      = !st_r.rb;
  assign take           = cmd_valid && cmd_ready;
  assign start_req      = (cmd_op == CSP_OP_STATE_RUN) || (cmd_op == CSP_OP_TRIGGER) ||
                          (cmd_op == CSP_OP_LAUNCH);
  assign exec_valid     = (st_r.run == CSP_RUN_ISSUE);
  assign exec_line      = st_r.ex_line;
  assign rd_valid       = st_r.rb;
  assign rd_line        = st_r.rd_line;
  assign rd_last        = st_r.rb && ((st_r.rb_idx + 1'b1) == st_r.len);
  assign recording      = st_r.rec;
  assign run_state      = st_r.run;
  assign dwell_s        = st_r.dwell;
  assign repeat_count   = st_r.rep;
  assign repeat_endless = st_r.endless;
  assign seq_len        = st_r.len;
  assign cmd_err        = st_r.err;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.err = 1'b0;

    // replay engine
    case (st_r.run)
      CSP_RUN_NEXT: begin
        if (st_r.pos >= st_r.len) begin
          st_nxt.pos = '0;
          if (st_r.endless) begin
            st_nxt.run = CSP_RUN_NEXT;
          end else if ((st_r.passes + 16'h0001) < st_r.rep) begin
            st_nxt.passes = st_r.passes + 16'h0001;
          end else begin
            st_nxt.run = CSP_RUN_IDLE;
          end
        end else begin
          // pointer moves past the command as it is issued, so pause resumes after it
          st_nxt.ex_line = st_r.mem[st_r.pos[AW-1:0]];
          st_nxt.pos     = st_r.pos + 1'b1;
          st_nxt.run     = CSP_RUN_ISSUE;
        end
      end
      CSP_RUN_ISSUE: begin
        if (exec_ready) begin
          st_nxt.wait_s = st_r.dwell;
          st_nxt.tick   = '0;
          st_nxt.run    = CSP_RUN_WAIT;
        end
      end
      CSP_RUN_WAIT: begin
        if (st_r.wait_s == 8'h00) begin
          st_nxt.run = CSP_RUN_NEXT;
        end else if (st_r.tick == TICK_LAST) begin
          st_nxt.tick   = '0;
          st_nxt.wait_s = st_r.wait_s - 8'h01;
        end else begin
          st_nxt.tick = st_r.tick + 1'b1;
        end
      end
      default: begin
      end
    endcase

    // readback drain
    if (st_r.rb && rd_ready) begin
      if ((st_r.rb_idx + 1'b1) >= st_r.len) begin
        st_nxt.rb = 1'b0;
      end else begin
        st_nxt.rb_idx  = st_r.rb_idx + 1'b1;
        st_nxt.rd_line = st_r.mem[st_nxt.rb_idx[AW-1:0]];
      end
    end

    // host commands keep being served whatever the replay engine is doing
    if (take) begin
      if (st_r.rec && (cmd_op != CSP_OP_REC_STOP)) begin
        // text is kept as sent; a full buffer drops the line and flags it
        if (st_r.len < DEPTH_L) begin
          st_nxt.mem[st_r.len[AW-1:0]] = cmd_line;
          st_nxt.len                   = st_r.len + 1'b1;
        end else begin
          st_nxt.err = 1'b1;
        end
      end else begin
        case (cmd_op)
          CSP_OP_REC_START: begin
            if ((cmd_src == CSP_SRC_BUS) || (cmd_src == CSP_SRC_LAN)) begin
              st_nxt.err = 1'b1;
            end else begin
              st_nxt.rec = 1'b1;
              st_nxt.len = '0;
              st_nxt.pos = '0;
              st_nxt.run = CSP_RUN_IDLE;
            end
          end
          CSP_OP_REC_STOP: begin
            st_nxt.rec = 1'b0;
          end
          CSP_OP_SET_DWELL: begin
            if (cmd_arg <= `CSP_ARG_W'(`CSP_DWELL_MAX)) begin
              st_nxt.dwell = cmd_arg[7:0];
            end else begin
              st_nxt.err = 1'b1;
            end
          end
          CSP_OP_SET_REPEAT: begin
            if (st_r.run != CSP_RUN_IDLE) begin
              st_nxt.err = 1'b1;
            end else if ((cmd_arg >= `CSP_ARG_W'(`CSP_REPEAT_MIN)) &&
                         (cmd_arg <= `CSP_ARG_W'(`CSP_REPEAT_MAX))) begin
              st_nxt.rep     = cmd_arg;
              st_nxt.endless = 1'b0;
            end else begin
              st_nxt.err = 1'b1;
            end
          end
          CSP_OP_SET_ENDLESS: begin
            if (st_r.run != CSP_RUN_IDLE) begin
              st_nxt.err = 1'b1;
            end else begin
              st_nxt.endless = 1'b1;
            end
          end
          CSP_OP_STATE_RUN, CSP_OP_TRIGGER, CSP_OP_LAUNCH: begin
            if (st_r.run == CSP_RUN_PAUSED) begin
              st_nxt.run = CSP_RUN_NEXT;
            end else if ((st_r.run == CSP_RUN_IDLE) && (st_r.len != '0)) begin
              st_nxt.passes = '0;
              st_nxt.run    = CSP_RUN_NEXT;
            end
          end
          CSP_OP_STATE_STOP: begin
            st_nxt.run = CSP_RUN_IDLE;
            st_nxt.pos = '0;
          end
          CSP_OP_STATE_PAUSE: begin
            if (st_r.run != CSP_RUN_IDLE) begin
              st_nxt.run = CSP_RUN_PAUSED;
            end
          end
          CSP_OP_READBACK: begin
            if (st_r.len != '0) begin
              st_nxt.rb      = 1'b1;
              st_nxt.rb_idx  = '0;
              st_nxt.rd_line = st_r.mem[0];
            end
          end
          CSP_OP_DELETE: begin
            st_nxt.len = '0;
            st_nxt.pos = '0;
            st_nxt.run = CSP_RUN_IDLE;
          end
          default: begin
          end
        endcase
        if (start_req && (st_r.run == CSP_RUN_IDLE) && (st_r.len == '0)) begin
          st_nxt.err = 1'b1;
        end
      end
    end
  end

  // buffer lives in plain flops with no retention, so power loss empties it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= '0;
      st_r.rep   <= `CSP_REPEAT_RST;
      st_r.dwell <= `CSP_DWELL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire
